// ===== rtl/rpgu_top.sv
/*
  Reset and input-gain update control: supply-monitor reset with extension, software
  reset at address zero, and left/right gain registers with pending/update semantics.
  Assumes supply monitors and slow timer clock arrive asynchronously, samples and the
  register port run on the 10 MHz system clock.
*/
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - internal reset holds all registers at defaults
// - register accesses ignored during internal reset
// - extend reset about 50 us after supplies valid
// - supply drop re-asserts reset, restarts extension
// - no readable indication of reset hold
// - any write to address zero restores defaults
// - write elsewhere ends software reset state
// - gain spans -12 to +35.25 dB, 0.75 dB steps
// - amplifier runs only with boost stage enabled
// - gain update bit is write-only, never stored
// - write without update stores gain as pending
// - update applies this and other pending gain
// - zero-cross enable defers change to crossing
// - zero-cross off applies change immediately on update
// - timeout forces deferred change after 2.5-3.0 periods
module rpgu_top
  import rpgu_pkg::*;
(
  input  wire logic                           clock,          // 10 MHz system clock
  input  wire logic                           rstn,           // async reset, active low
  input  wire logic                           analogSupplyOk, // analog supply monitor
  input  wire logic                           coreSupplyOk,   // core supply monitor
  input  wire logic                           slowTimerClk,   // slow timer clock level
  input  wire logic [ADDR_W-1:0]              regAddr,        // register address
  input  wire logic [DATA_W-1:0]              regWdata,       // register write data
  input  wire logic                           regWrite,       // write strobe
  input  wire logic                           regRead,        // read strobe
  output logic      [DATA_W-1:0]              regRdata,       // read data, next cycle
  input  wire logic [NCHAN-1:0]               sampleValid,    // per-channel sample strobe
  input  wire logic [NCHAN-1:0][SAMPLE_W-1:0] sample,         // signed input samples
  output logic      [NCHAN-1:0][GAIN_W-1:0]   activeGain,     // gain codes in effect
  output logic      [NCHAN-1:0]               gainMute,       // channel mute
  output logic      [NCHAN-1:0]               pgaActive,      // amplifier path running
  output logic      [NCHAN-1:0]               alcEnable,      // level control enable
  output logic      [NCHAN-1:0]               gainDeferred    // change awaits crossing
);

  // ---------------------------------------------------------------------------
  // reset release and input synchronisers
  // ---------------------------------------------------------------------------
  logic       rstnMeta_reg;
  logic       rstnSync;
  logic [2:0] supMeta_reg;
  logic [2:0] supSync_reg;
  logic       slowPrev_reg;
  logic       suppliesOk;
  logic       slowEdge;

  // reset leaves asynchronously asserted, released over two flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstnMeta_reg <= 1'b0;
      rstnSync     <= 1'b0;
    end else begin
      rstnMeta_reg <= 1'b1;
      rstnSync     <= rstnMeta_reg;
    end
  end

  // monitors and slow clock are asynchronous: first flop feeds only the second
  always_ff @(posedge clock or negedge rstnSync) begin
    if (!rstnSync) begin
      supMeta_reg  <= '0;
      supSync_reg  <= '0;
      slowPrev_reg <= 1'b0;
    end else begin
      supMeta_reg  <= {slowTimerClk, coreSupplyOk, analogSupplyOk};
      supSync_reg  <= supMeta_reg;
      slowPrev_reg <= supSync_reg[2];
    end
  end

  assign suppliesOk = supSync_reg[0] && supSync_reg[1];
  assign slowEdge   = supSync_reg[2] ^ slowPrev_reg;

  // ---------------------------------------------------------------------------
  // power-on reset sequencer
  // ---------------------------------------------------------------------------
  rpgu_por_t           porState_reg;
  logic [EXT_CNT_W-1:0] extCnt_reg;
  logic                porHold;

  // any monitor dropping sends the sequencer back to hold from every state
  always_ff @(posedge clock or negedge rstnSync) begin
    if (!rstnSync) begin
      porState_reg <= POR_HOLD;
      extCnt_reg   <= '0;
    end else if (!suppliesOk) begin
      porState_reg <= POR_HOLD;
      extCnt_reg   <= '0;
    end else begin
      unique case (porState_reg)
        POR_HOLD: begin
          porState_reg <= POR_EXTEND;
          extCnt_reg   <= '0;
        end
        POR_EXTEND: begin
          if (extCnt_reg == EXT_LAST) begin
            porState_reg <= POR_RUN;
          end else begin
            extCnt_reg <= extCnt_reg + 10'h001;
          end
        end
        POR_RUN: begin
          porState_reg <= POR_RUN;
        end
        default: begin
          porState_reg <= POR_HOLD;
        end
      endcase
    end
  end

  assign porHold = (porState_reg != POR_RUN);

  // ---------------------------------------------------------------------------
  // access qualification
  // ---------------------------------------------------------------------------
  logic wrOk;
  logic rdOk;
  logic softResetWr;
  logic clearAll;
  logic swResetHeld_reg;

  // accesses during the internal reset are dropped outright
  assign wrOk        = regWrite && !porHold;
  assign rdOk        = regRead && !porHold;
  assign softResetWr = wrOk && (regAddr == ADDR_SOFTWARE_RESET);
  assign clearAll    = porHold || softResetWr;

  // software reset state lasts until a write to another address
  always_ff @(posedge clock or negedge rstnSync) begin
    if (!rstnSync) begin
      swResetHeld_reg <= 1'b0;
    end else if (softResetWr) begin
      swResetHeld_reg <= 1'b1;
    end else if (wrOk) begin
      swResetHeld_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] powerCtrl_reg;
  logic [DATA_W-1:0] zcTimeout_reg;
  logic [DATA_W-1:0] levelCfg_reg;

  // held at defaults while either reset source is active
  always_ff @(posedge clock or negedge rstnSync) begin
    if (!rstnSync) begin
      powerCtrl_reg <= PWR_RST;
      zcTimeout_reg <= ZC_TIMEOUT_RST;
      levelCfg_reg  <= LEVEL_RST;
    end else if (clearAll) begin
      powerCtrl_reg <= PWR_RST;
      zcTimeout_reg <= ZC_TIMEOUT_RST;
      levelCfg_reg  <= LEVEL_RST;
    end else if (wrOk) begin
      if (regAddr == ADDR_INPUT_POWER_CTRL) powerCtrl_reg <= regWdata;
      if (regAddr == ADDR_ZC_TIMEOUT_CTRL) zcTimeout_reg <= regWdata;
      if (regAddr == ADDR_LEVEL_CONTROL_CFG) levelCfg_reg <= regWdata;
    end
  end

  // ---------------------------------------------------------------------------
  // per-channel gain registers and update engines
  // ---------------------------------------------------------------------------
  rpgu_gain_t        gainReg_reg [NCHAN];
  logic [NCHAN-1:0]  gainHit;
  logic              updateWr;
  logic              timeoutEn;

  assign timeoutEn = zcTimeout_reg[ZC_TIMEOUT_BIT];
  // the update bit acts on the write carrying it and is never stored
  assign updateWr  = (|gainHit) && regWdata[GAIN_UPDATE_BIT];

  genvar ch;
  generate
    for (ch = 0; ch < NCHAN; ch++) begin : gChan
      logic [ADDR_W-1:0] chAddr;
      assign chAddr      = (ch == 0) ? ADDR_LEFT_INPUT_GAIN : ADDR_RIGHT_INPUT_GAIN;
      assign gainHit[ch] = wrOk && (regAddr == chAddr);

      // stored value is the pending one; its mute bit drives gainMute without a commit
      always_ff @(posedge clock or negedge rstnSync) begin
        if (!rstnSync) begin
          gainReg_reg[ch] <= rpgu_gain_t'(GAIN_RST[7:0]);
        end else if (clearAll) begin
          gainReg_reg[ch] <= rpgu_gain_t'(GAIN_RST[7:0]);
        end else if (gainHit[ch]) begin
          gainReg_reg[ch] <= rpgu_gain_t'(regWdata[7:0]);
        end
      end

      // committed code: this write's data for the written channel, else stored
      logic [GAIN_W-1:0] commitCode;
      logic              commitZc;
      assign commitCode = gainHit[ch] ? regWdata[GAIN_W-1:0] : gainReg_reg[ch].gain;
      assign commitZc   = gainHit[ch] ? regWdata[GAIN_ZC_BIT] : gainReg_reg[ch].zcEn;

      rpgu_chan uChan (
        .clock       (clock),
        .rstnSync    (rstnSync),
        .clear       (clearAll),
        .commit      (updateWr),
        .target      (commitCode),
        .zcEn        (commitZc),
        .timeoutEn   (timeoutEn),
        .slowEdge    (slowEdge),
        .sampleValid (sampleValid[ch]),
        .sampleSign  (sample[ch][SAMPLE_W-1]),
        .activeGain  (activeGain[ch]),
        .deferred    (gainDeferred[ch])
      );

      // path runs only with amplifier and boost stage both powered
      always_ff @(posedge clock or negedge rstnSync) begin
        if (!rstnSync) begin
          pgaActive[ch] <= 1'b0;
          gainMute[ch]  <= 1'b0;
          alcEnable[ch] <= 1'b0;
        end else begin
          pgaActive[ch] <= powerCtrl_reg[PWR_PGA_LSB + ch]
                           && powerCtrl_reg[PWR_BOOST_LSB + ch]
                           && !swResetHeld_reg && !porHold;
          gainMute[ch]  <= gainReg_reg[ch].mute;
          alcEnable[ch] <= levelCfg_reg[LEVEL_ALC_LSB + ch];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] rdMux;

  // reads return written values so the host can poll for release; the update bit
  // reads zero and nothing exposes the reset hold itself
  always_comb begin
    rdMux = '0;
    unique case (regAddr)
      ADDR_INPUT_POWER_CTRL:  rdMux = powerCtrl_reg;
      ADDR_ZC_TIMEOUT_CTRL:   rdMux = zcTimeout_reg;
      ADDR_LEVEL_CONTROL_CFG: rdMux = levelCfg_reg;
      ADDR_LEFT_INPUT_GAIN:   rdMux = {1'b0, gainReg_reg[0]};
      ADDR_RIGHT_INPUT_GAIN:  rdMux = {1'b0, gainReg_reg[1]};
      ADDR_LEFT_ACTIVE_GAIN:  rdMux = {gainDeferred[0], 2'b00, activeGain[0]};
      ADDR_RIGHT_ACTIVE_GAIN: rdMux = {gainDeferred[1], 2'b00, activeGain[1]};
      default:                rdMux = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clock or negedge rstnSync) begin
    if (!rstnSync) begin
      regRdata <= '0;
    end else if (rdOk) begin
      regRdata <= rdMux;
    end else begin
      regRdata <= '0;
    end
  end

endmodule

`default_nettype wire

// ===== shared/rpgu_pkg.sv
/*
  Package for the reset and input-gain update block: register offsets, field positions,
  reset values, timing counts and the shared types.
  Assumes a 10 MHz system clock and a 7-bit address, 9-bit data control port.
*/
`default_nettype none

package rpgu_pkg;

  // ---------------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------------
  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 9;
  localparam int GAIN_W   = 6;
  localparam int SAMPLE_W = 16;
  localparam int NCHAN    = 2;

  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_SOFTWARE_RESET     = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_INPUT_POWER_CTRL   = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_ZC_TIMEOUT_CTRL    = 7'h07;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_CONTROL_CFG  = 7'h20;
  localparam logic [ADDR_W-1:0] ADDR_LEFT_INPUT_GAIN    = 7'h2d;
  localparam logic [ADDR_W-1:0] ADDR_RIGHT_INPUT_GAIN   = 7'h2e;
  localparam logic [ADDR_W-1:0] ADDR_LEFT_ACTIVE_GAIN   = 7'h3e;
  localparam logic [ADDR_W-1:0] ADDR_RIGHT_ACTIVE_GAIN  = 7'h3f;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int GAIN_UPDATE_BIT = 8;   // write-only commit bit
  localparam int GAIN_ZC_BIT     = 7;   // zero-cross enable
  localparam int GAIN_MUTE_BIT   = 6;
  localparam int GAIN_LSB        = 0;
  localparam int PWR_PGA_LSB     = 2;   // bit 2 left, bit 3 right
  localparam int PWR_BOOST_LSB   = 4;   // bit 4 left, bit 5 right
  localparam int ZC_TIMEOUT_BIT  = 0;
  localparam int LEVEL_ALC_LSB   = 7;   // bit 7 left, bit 8 right

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [DATA_W-1:0] GAIN_RST      = 9'h010;  // code 16 is 0 dB
  localparam logic [DATA_W-1:0] PWR_RST       = 9'h000;
  localparam logic [DATA_W-1:0] ZC_TIMEOUT_RST = 9'h000;
  localparam logic [DATA_W-1:0] LEVEL_RST     = 9'h000;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int EXT_TIME_NS   = 50000;   // nominal reset extension
  localparam int EXT_MAX_NS    = 100000;  // upper bound, not to be passed
  localparam int EXT_CYCLES    = (EXT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_CNT_W     = 10;
  localparam logic [EXT_CNT_W-1:0] EXT_LAST = EXT_CNT_W'(EXT_CYCLES - 1);
  // six slow-clock edges after deferral: 2.5 to 3.0 slow periods
  localparam int TO_CNT_W = 3;
  localparam logic [TO_CNT_W-1:0] TIMEOUT_EDGES = 3'h6;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic              zcEn;
    logic              mute;
    logic [GAIN_W-1:0] gain;
  } rpgu_gain_t;

  typedef enum logic [1:0] {
    POR_HOLD   = 2'b00,
    POR_EXTEND = 2'b01,
    POR_RUN    = 2'b11
  } rpgu_por_t;

endpackage

`default_nettype wire

// ===== rtl/rpgu_chan.sv
/*
  One input amplifier channel: takes committed gain codes and applies them at once or
  deferred to a zero crossing, with an optional slow-clock timeout.
  Assumes all inputs are on the system clock; clear is a synchronous default load.
*/
`timescale 1ns/1ns
`default_nettype none

module rpgu_chan
  import rpgu_pkg::*;
(
  input  wire logic              clock,       // system clock
  input  wire logic              rstnSync,    // synchronised reset, active low
  input  wire logic              clear,       // load defaults
  input  wire logic              commit,      // apply target now or deferred
  input  wire logic [GAIN_W-1:0] target,      // committed gain code
  input  wire logic              zcEn,        // zero-cross gating on
  input  wire logic              timeoutEn,   // zero-cross timeout on
  input  wire logic              slowEdge,    // either edge of slow timer clock
  input  wire logic              sampleValid, // new input sample
  input  wire logic              sampleSign,  // sign of that sample
  output logic [GAIN_W-1:0]      activeGain,  // gain in effect
  output logic                   deferred     // change waiting for a crossing
);

  // ---------------------------------------------------------------------------
  // zero-cross detection
  // ---------------------------------------------------------------------------
  logic lastSign_reg;
  logic zeroCross;

  // a crossing is a sign change between successive samples
  assign zeroCross = sampleValid && (sampleSign != lastSign_reg);

  always_ff @(posedge clock or negedge rstnSync) begin
    if (!rstnSync) begin
      lastSign_reg <= 1'b0;
    end else if (sampleValid) begin
      lastSign_reg <= sampleSign;
    end
  end

  // ---------------------------------------------------------------------------
  // gain application
  // ---------------------------------------------------------------------------
  logic [GAIN_W-1:0]   held_reg;
  logic [TO_CNT_W-1:0] toCnt_reg;
  logic                timedOut;

  assign timedOut = timeoutEn && slowEdge && (toCnt_reg == TIMEOUT_EDGES - 3'h1);

  // a new commit while deferred replaces the waiting code and restarts the timeout
  always_ff @(posedge clock or negedge rstnSync) begin
    if (!rstnSync) begin
      activeGain <= GAIN_RST[GAIN_W-1:0];
      held_reg   <= GAIN_RST[GAIN_W-1:0];
      deferred   <= 1'b0;
      toCnt_reg  <= '0;
    end else if (clear) begin
      activeGain <= GAIN_RST[GAIN_W-1:0];
      held_reg   <= GAIN_RST[GAIN_W-1:0];
      deferred   <= 1'b0;
      toCnt_reg  <= '0;
    end else if (commit) begin
      toCnt_reg <= '0;
      if (zcEn) begin
        held_reg <= target;
        deferred <= 1'b1;
      end else begin
        activeGain <= target;
        deferred   <= 1'b0;
      end
    end else if (deferred) begin
      if (zeroCross || timedOut || !zcEn) begin
        activeGain <= held_reg;
        deferred   <= 1'b0;
        toCnt_reg  <= '0;
      end else if (slowEdge && timeoutEn) begin
        toCnt_reg <= toCnt_reg + 3'h1;
      end
    end
  end

endmodule

`default_nettype wire

// ===== dv/rpgu_top_monitor.sv
/*
  Port checker for the gain update block, bound into rpgu_top.
  Assumes only the left channel gets samples.
*/
`timescale 1ns/1ns
`default_nettype none

module rpgu_top_monitor
  import rpgu_pkg::*;
(
  input wire logic                           clock,          // system clock
  input wire logic                           rstn,           // async reset, active low
  input wire logic                           analogSupplyOk, // analog supply monitor
  input wire logic                           coreSupplyOk,   // core supply monitor
  input wire logic [ADDR_W-1:0]              regAddr,        // register address
  input wire logic [DATA_W-1:0]              regWdata,       // write data
  input wire logic                           regWrite,       // write strobe
  input wire logic                           regRead,        // read strobe
  input wire logic [DATA_W-1:0]              regRdata,       // read data
  input wire logic [NCHAN-1:0]               sampleValid,    // sample strobes
  input wire logic [NCHAN-1:0][SAMPLE_W-1:0] sample,         // input samples
  input wire logic [NCHAN-1:0][GAIN_W-1:0]   activeGain,     // gains in effect
  input wire logic [NCHAN-1:0]               pgaActive,      // amplifier running
  input wire logic [NCHAN-1:0]               alcEnable,      // level control enable
  input wire logic [NCHAN-1:0]               gainDeferred    // change awaits crossing
);
  logic [9:0] upCnt;    // cycles with reset and both supplies released
  logic       prevSign; // sign of the last left sample
  logic       live;     // extension surely over

  // ----------
  // helper state
  // ----------
  // a supply drop restarts the count, mirroring the extension restart
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) upCnt <= 10'h000;
    else if (!(analogSupplyOk && coreSupplyOk)) upCnt <= 10'h000;
    else if (upCnt != 10'h3ff) upCnt <= upCnt + 10'h001;
  end
  // sign history for the crossing check
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) prevSign <= 1'b0;
    else if (sampleValid[0]) prevSign <= sample[0][SAMPLE_W-1];
  end
  assign live = (upCnt >= 10'h208);  // margin over sync delays

  // ----------
  // properties
  // ----------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence swReset;
    live && regWrite && regAddr == ADDR_SOFTWARE_RESET;
  endsequence
  sequence defaultsBack;
    activeGain == {2{GAIN_RST[GAIN_W-1:0]}} ##1 pgaActive == 2'b00;
  endsequence
  sequence leftCommit;
    live && regWrite && regAddr == ADDR_LEFT_INPUT_GAIN && regWdata[GAIN_UPDATE_BIT];
  endsequence

  hold_defaults_a: assert property (
    (!(analogSupplyOk && coreSupplyOk))[*6] |-> activeGain == {2{GAIN_RST[GAIN_W-1:0]}}
      && pgaActive == 2'b00 && alcEnable == 2'b00) else $error("defaults not held");
  ext_hold_a: assert property (
    upCnt >= 10'h008 && upCnt < 10'h1f4 |-> pgaActive == 2'b00 && alcEnable == 2'b00)
    else $error("control active during extension");
  rd_hold_a: assert property (
    $past(regRead) && $past(upCnt) >= 10'h008 && $past(upCnt) < 10'h1f4 |-> regRdata == 9'h000)
    else $error("read answered during hold");
  rd_idle_a: assert property (!$past(regRead) |-> regRdata == 9'h000)
    else $error("read data outside answer cycle");
  upd_wo_a: assert property (
    $past(regRead) && ($past(regAddr) == ADDR_LEFT_INPUT_GAIN
      || $past(regAddr) == ADDR_RIGHT_INPUT_GAIN) |-> !regRdata[GAIN_UPDATE_BIT])
    else $error("update bit readable");
  pend_keep_a: assert property (
    live && regWrite && regAddr == ADDR_LEFT_INPUT_GAIN && !regWdata[GAIN_UPDATE_BIT]
      && !gainDeferred[0] |=> $stable(activeGain[0])) else $error("pending gain applied");
  now_apply_a: assert property (
    leftCommit ##0 !regWdata[GAIN_ZC_BIT] |=> activeGain[0] == $past(regWdata[GAIN_W-1:0]))
    else $error("gain not applied on update");
  zc_defer_a: assert property (
    leftCommit ##0 regWdata[GAIN_ZC_BIT] |=> gainDeferred[0]) else $error("change not deferred");
  zc_release_a: assert property (
    gainDeferred[0] && sampleValid[0] && sample[0][SAMPLE_W-1] != prevSign
      |-> ##[1:2] !gainDeferred[0]) else $error("crossing did not release change");
  soft_reset_a: assert property (swReset |=> defaultsBack)
    else $error("software reset missed defaults");
endmodule

bind rpgu_top rpgu_top_monitor mon_u (.clock, .rstn, .analogSupplyOk, .coreSupplyOk,
  .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .sampleValid, .sample, .activeGain,
  .pgaActive, .alcEnable, .gainDeferred);

`default_nettype wire

// ===== dv/rpgu_host.sv
/*
  Host model: one-cycle register strobes, release polling.
  Assumes a slave that never stalls.
*/
`timescale 1ns/1ns
`default_nettype none

module rpgu_host
  import rpgu_pkg::*;
(
  input  wire logic              clock,    // system clock
  input  wire logic [DATA_W-1:0] regRdata, // read answer
  output logic      [ADDR_W-1:0] regAddr,  // address
  output logic      [DATA_W-1:0] regWdata, // write data
  output logic                   regWrite, // write strobe
  output logic                   regRead   // read strobe
);
  // idle bus
  initial {regAddr, regWdata, regWrite, regRead} = '0;
  // data flipped after release so a stale value never looks valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regWdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask
  // write a non-default value and read back until it sticks
  task automatic pollRelease(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    int n = 0;
    do begin
      wr(a, d);
      rd(a, q);
      n++;
    end while (q !== d && n < 300);
  endtask
endmodule

`default_nettype wire

// ===== dv/rpgu_top_test.sv
/*
  Self-checking bench for the gain update block.
  Assumes rpgu_host as master; slow timer period is 40 cycles.
*/
`timescale 1ns/1ns
`default_nettype none

module rpgu_top_test
  import rpgu_pkg::*;
;
  logic clock, rstn, analogSupplyOk, coreSupplyOk, slowTimerClk;
  logic [ADDR_W-1:0]              regAddr;
  logic [DATA_W-1:0]              regWdata, regRdata, q;
  logic                           regWrite, regRead;
  logic [NCHAN-1:0]               sampleValid, gainMute, pgaActive, alcEnable, gainDeferred;
  logic [NCHAN-1:0][SAMPLE_W-1:0] sample;
  logic [NCHAN-1:0][GAIN_W-1:0]   activeGain;
  int                             miscompares, checksDone, slowCnt;
  longint                         t0;

  rpgu_host host_u (.clock, .regRdata, .regAddr, .regWdata, .regWrite, .regRead);
  rpgu_top dut_u (.clock, .rstn, .analogSupplyOk, .coreSupplyOk, .slowTimerClk, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata, .sampleValid, .sample, .activeGain,
    .gainMute, .pgaActive, .alcEnable, .gainDeferred);

  // ----------
  // clocks and helpers
  // ----------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // slow timer runs free, unrelated to any register traffic
  always @(posedge clock) begin
    slowCnt <= (slowCnt == 19) ? 0 : slowCnt + 1;
    if (slowCnt == 19) slowTimerClk <= ~slowTimerClk;
  end
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checksDone++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkTime(input string n, input int lo, input int hi, input int g);
    checksDone++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic waitCyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic relCheck();
    host_u.pollRelease(ADDR_LEVEL_CONTROL_CFG, 9'h080);
    chkTime("release cycles", 500, 1000, int'(($time - t0) / CLK_PERIOD_NS));
    waitCyc(2);
    chk("alc after release", 12'h001, alcEnable);
  endtask
  task automatic sendSample(input logic [SAMPLE_W-1:0] s);
    @(posedge clock);
    sampleValid <= 2'b01;
    sample[0] <= s;
    @(posedge clock);
    sampleValid <= 2'b00;
    sample[0] <= ~s;
    waitCyc(2);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && checksDone > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------
  // scenarios
  // ----------
  initial begin
    {rstn, slowTimerClk, sampleValid, sample, miscompares, checksDone, slowCnt} = '0;
    {analogSupplyOk, coreSupplyOk} = 2'b11;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    t0 = $time;
    host_u.wr(ADDR_LEFT_INPUT_GAIN, 9'h120);
    host_u.rd(ADDR_LEFT_INPUT_GAIN, q);
    chk("gain read in hold", 12'h000, q);
    chk("gain in hold", {2{6'h10}}, activeGain);
    relCheck();
    host_u.wr(ADDR_SOFTWARE_RESET, 9'h155);
    waitCyc(2);
    chk("alc after soft reset", 12'h000, alcEnable);
    host_u.rd(ADDR_LEVEL_CONTROL_CFG, q);
    chk("level cfg after soft reset", 12'h000, q);
    host_u.wr(ADDR_INPUT_POWER_CTRL, 9'h00c);
    waitCyc(2);
    chk("amp without boost", 12'h000, pgaActive);
    host_u.wr(ADDR_INPUT_POWER_CTRL, 9'h03c);
    waitCyc(2);
    chk("amp with boost", 12'h003, pgaActive);
    host_u.wr(ADDR_LEFT_INPUT_GAIN, 9'h060);
    chk("left pending", {6'h10, 6'h10}, activeGain);
    host_u.rd(ADDR_LEFT_INPUT_GAIN, q);
    chk("left stored", 12'h060, q);
    chk("left mute", 12'h001, gainMute);
    host_u.wr(ADDR_RIGHT_INPUT_GAIN, 9'h118);
    chk("pair applied", {6'h18, 6'h20}, activeGain);
    host_u.rd(ADDR_RIGHT_INPUT_GAIN, q);
    chk("right read", 12'h018, q);
    host_u.wr(ADDR_LEFT_INPUT_GAIN, 9'h100);
    chk("lowest code", 12'h000, activeGain[0]);
    host_u.wr(ADDR_LEFT_INPUT_GAIN, 9'h13f);
    chk("highest code", 12'h03f, activeGain[0]);
    host_u.rd(7'h55, q);
    chk("unmapped read", 12'h000, q);
    host_u.wr(ADDR_LEFT_INPUT_GAIN, 9'h1a5);
    waitCyc(1);
    chk("zc deferred", 12'h001, gainDeferred);
    chk("zc held gain", 12'h03f, activeGain[0]);
    host_u.rd(ADDR_LEFT_ACTIVE_GAIN, q);
    chk("active readback", 12'h13f, q);
    sendSample(16'h1234);
    chk("no crossing", 12'h03f, activeGain[0]);
    sendSample(16'h8000);
    chk("crossing applied", 12'h025, activeGain[0]);
    sendSample(16'h0001);
    host_u.wr(ADDR_ZC_TIMEOUT_CTRL, 9'h001);
    host_u.wr(ADDR_LEFT_INPUT_GAIN, 9'h1aa);
    waitCyc(96);
    chk("timeout early", 12'h001, gainDeferred);
    waitCyc(44);
    chk("timeout applied", 12'h02a, activeGain[0]);
    coreSupplyOk <= 1'b0;
    waitCyc(6);
    chk("drop gain", {2{6'h10}}, activeGain);
    chk("drop amp", 12'h000, pgaActive);
    coreSupplyOk <= 1'b1;
    t0 = $time;
    relCheck();
    finish_test();
  end
  // a hang counts as a failure; the run needs about 1220 cycles
  initial begin
    #(CLK_PERIOD_NS * 20000);
    miscompares++;
    finish_test();
  end
endmodule

`default_nettype wire
